// ==== pbfm_defines.svh ====
`ifndef PBFM_DEFINES_SVH
`define PBFM_DEFINES_SVH

// Register offsets on the plain register port.
`define PBFM_ADDR_W 4
`define PBFM_OFF_B_PULLUP 4'h0
`define PBFM_OFF_B_PER 4'h1
`define PBFM_OFF_B_DDR 4'h2
`define PBFM_OFF_B_DATA 4'h3
`define PBFM_OFF_B_PIN 4'h4
`define PBFM_OFF_F_PULLUP 4'h5
`define PBFM_OFF_F_PER 4'h6
`define PBFM_OFF_F_DDR 4'h7
`define PBFM_OFF_F_DATA 4'h8
`define PBFM_OFF_F_PIN 4'h9
`define PBFM_OFF_CLKOUT_SEL 4'hA
`define PBFM_OFF_BUS_CTRL 4'hB

// Field positions.
`define PBFM_SHARED_PIN 4
`define PBFM_DRV_BIT 0

// Reset values.
`define PBFM_RST_B_PULLUP 5'h1F
`define PBFM_RST_B_PER 5'h1F
`define PBFM_RST_B_DDR 5'h00
`define PBFM_RST_B_DATA 5'h00
`define PBFM_RST_F_PULLUP 4'hF
`define PBFM_RST_F_PER 4'hF
`define PBFM_RST_F_DDR 4'h0
`define PBFM_RST_F_DATA 4'h0
`define PBFM_RST_CLKOUT_SEL 1'h0
`define PBFM_RST_BUS_CTRL 1'h0

`endif

// ==== pbfm_pkg.sv ====
package pbfm_pkg;

    // Function that the shared address/clock pin carries.
    typedef enum logic [1:0] {
        PBFM_FN_GPIO,
        PBFM_FN_ADDR,
        PBFM_FN_CLK
    } pbfm_fn_e;

endpackage

// ==== pbfm_pin_cell.sv ====
`timescale 1ns/1ps
`default_nettype none

// One shared pin: GPIO or peripheral drive, registered outputs, synchronised input.
module pbfm_pin_cell (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic gpio_sel,
    input wire logic gpio_dir_out,
    input wire logic gpio_data,
    input wire logic periph_out,
    input wire logic periph_oe,
    input wire logic pullup_en,
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe,
    output logic pad_pullup,
    output logic pin_sync
);

    logic meta_q;
    logic sync_q;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pad_out <= 1'h0;
            pad_oe <= 1'h0;
        end else if (gpio_sel) begin
            pad_out <= gpio_data;
            pad_oe <= gpio_dir_out;
        end else begin
            pad_out <= periph_out;
            pad_oe <= periph_oe;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pad_pullup <= 1'h1;
        end else begin
            pad_pullup <= pullup_en;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            meta_q <= 1'h0;
            sync_q <= 1'h0;
        end else begin
            meta_q <= pad_in;
            sync_q <= meta_q;
        end
    end

    assign pin_sync = sync_q;

endmodule

`default_nettype wire

// ==== pbfm_port_b_f_mux.sv ====
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pbfm_defines.svh"

module pbfm_port_b_f_mux #(
    parameter int PB_W = 5,
    parameter int PF_W = 4
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [`PBFM_ADDR_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic [PB_W-1:0] emi_addr_out,
    input wire logic [PF_W-1:0] emi_data_out,
    input wire logic emi_data_oe,
    input wire logic emi_bus_active,
    input wire logic prescaler_clock,
    input wire logic [PB_W-1:0] pb_pad_in,
    output logic [PB_W-1:0] pb_pad_out,
    output logic [PB_W-1:0] pb_pad_oe,
    output logic [PB_W-1:0] pb_pad_pullup,
    input wire logic [PF_W-1:0] pf_pad_in,
    output logic [PF_W-1:0] pf_pad_out,
    output logic [PF_W-1:0] pf_pad_oe,
    output logic [PF_W-1:0] pf_pad_pullup,
    output logic [PF_W-1:0] emi_data_in,
    output logic emi_ctrl_oe,
    output var pbfm_pkg::pbfm_fn_e shared_pin_fn
);

    // ********************************************************************
    // Registers
    // ********************************************************************
    logic [PB_W-1:0] b_pullup_q;
    logic [PB_W-1:0] b_per_q;
    logic [PB_W-1:0] b_ddr_q;
    logic [PB_W-1:0] b_data_q;
    logic [PF_W-1:0] f_pullup_q;
    logic [PF_W-1:0] f_per_q;
    logic [PF_W-1:0] f_ddr_q;
    logic [PF_W-1:0] f_data_q;
    logic clkout_sel_q;
    logic bus_drive_q;
    logic [PB_W-1:0] b_pin_sync;
    logic [PF_W-1:0] f_pin_sync;

    function automatic logic hit(input logic [`PBFM_ADDR_W-1:0] off);
        hit = reg_wr && (reg_addr == off);
    endfunction

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            b_pullup_q <= PB_W'(`PBFM_RST_B_PULLUP);
            f_pullup_q <= PF_W'(`PBFM_RST_F_PULLUP);
        end else begin
            if (hit(`PBFM_OFF_B_PULLUP)) begin
                b_pullup_q <= reg_wdata[PB_W-1:0];
            end
            if (hit(`PBFM_OFF_F_PULLUP)) begin
                f_pullup_q <= reg_wdata[PF_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            b_per_q <= PB_W'(`PBFM_RST_B_PER);
            f_per_q <= PF_W'(`PBFM_RST_F_PER);
        end else begin
            if (hit(`PBFM_OFF_B_PER)) begin
                b_per_q <= reg_wdata[PB_W-1:0];
            end
            if (hit(`PBFM_OFF_F_PER)) begin
                f_per_q <= reg_wdata[PF_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            b_ddr_q <= PB_W'(`PBFM_RST_B_DDR);
            f_ddr_q <= PF_W'(`PBFM_RST_F_DDR);
            b_data_q <= PB_W'(`PBFM_RST_B_DATA);
            f_data_q <= PF_W'(`PBFM_RST_F_DATA);
        end else begin
            if (hit(`PBFM_OFF_B_DDR)) begin
                b_ddr_q <= reg_wdata[PB_W-1:0];
            end
            if (hit(`PBFM_OFF_F_DDR)) begin
                f_ddr_q <= reg_wdata[PF_W-1:0];
            end
            if (hit(`PBFM_OFF_B_DATA)) begin
                b_data_q <= reg_wdata[PB_W-1:0];
            end
            if (hit(`PBFM_OFF_F_DATA)) begin
                f_data_q <= reg_wdata[PF_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            clkout_sel_q <= `PBFM_RST_CLKOUT_SEL;
            bus_drive_q <= `PBFM_RST_BUS_CTRL;
        end else begin
            if (hit(`PBFM_OFF_CLKOUT_SEL)) begin
                clkout_sel_q <= reg_wdata[0];
            end
            if (hit(`PBFM_OFF_BUS_CTRL)) begin
                bus_drive_q <= reg_wdata[`PBFM_DRV_BIT];
            end
        end
    end

    // ********************************************************************
    // Read port
    // ********************************************************************
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `PBFM_OFF_B_PULLUP: reg_rdata <= 16'(b_pullup_q);
                `PBFM_OFF_B_PER: reg_rdata <= 16'(b_per_q);
                `PBFM_OFF_B_DDR: reg_rdata <= 16'(b_ddr_q);
                `PBFM_OFF_B_DATA: reg_rdata <= 16'(b_data_q);
                `PBFM_OFF_B_PIN: reg_rdata <= 16'(b_pin_sync);
                `PBFM_OFF_F_PULLUP: reg_rdata <= 16'(f_pullup_q);
                `PBFM_OFF_F_PER: reg_rdata <= 16'(f_per_q);
                `PBFM_OFF_F_DDR: reg_rdata <= 16'(f_ddr_q);
                `PBFM_OFF_F_DATA: reg_rdata <= 16'(f_data_q);
                `PBFM_OFF_F_PIN: reg_rdata <= 16'(f_pin_sync);
                `PBFM_OFF_CLKOUT_SEL: reg_rdata <= 16'(clkout_sel_q);
                `PBFM_OFF_BUS_CTRL: reg_rdata <= 16'(bus_drive_q);
                default: reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ********************************************************************
    // Peripheral drive
    // ********************************************************************
    // Address outputs and the control enable drive while the bus is active or when drive select forces them; port F data also needs emi_data_oe.
    logic bus_drive_en;
    assign bus_drive_en = emi_bus_active || bus_drive_q;

    logic [PB_W-1:0] b_periph_out;
    logic [PB_W-1:0] b_periph_oe;
    always_comb begin
        b_periph_out = emi_addr_out;
        b_periph_oe = {PB_W{bus_drive_en}};
        if (clkout_sel_q) begin
            b_periph_out[`PBFM_SHARED_PIN] = prescaler_clock;
            b_periph_oe[`PBFM_SHARED_PIN] = 1'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            emi_ctrl_oe <= 1'h0;
            shared_pin_fn <= pbfm_pkg::PBFM_FN_GPIO;
        end else begin
            emi_ctrl_oe <= bus_drive_en;
            if (b_per_q[`PBFM_SHARED_PIN]) begin
                shared_pin_fn <= pbfm_pkg::PBFM_FN_GPIO;
            end else if (clkout_sel_q) begin
                shared_pin_fn <= pbfm_pkg::PBFM_FN_CLK;
            end else begin
                shared_pin_fn <= pbfm_pkg::PBFM_FN_ADDR;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            emi_data_in <= '0;
        end else begin
            emi_data_in <= f_pin_sync;
        end
    end

    // ********************************************************************
    // Pin cells
    // ********************************************************************
    // On port B peripheral-enable set means GPIO and clear hands the pin to the alternate function; port F is the reverse.
    for (genvar i = 0; i < PB_W; i++) begin : g_pb
        pbfm_pin_cell u_cell (
            .clk_sys(clk_sys),
            .rstn(rstn),
            .gpio_sel(b_per_q[i]),
            .gpio_dir_out(b_ddr_q[i]),
            .gpio_data(b_data_q[i]),
            .periph_out(b_periph_out[i]),
            .periph_oe(b_periph_oe[i]),
            .pullup_en(b_pullup_q[i]),
            .pad_in(pb_pad_in[i]),
            .pad_out(pb_pad_out[i]),
            .pad_oe(pb_pad_oe[i]),
            .pad_pullup(pb_pad_pullup[i]),
            .pin_sync(b_pin_sync[i])
        );
    end

    for (genvar j = 0; j < PF_W; j++) begin : g_pf
        pbfm_pin_cell u_cell (
            .clk_sys(clk_sys),
            .rstn(rstn),
            .gpio_sel(!f_per_q[j]),
            .gpio_dir_out(f_ddr_q[j]),
            .gpio_data(f_data_q[j]),
            .periph_out(emi_data_out[j]),
            .periph_oe(emi_data_oe && bus_drive_en),
            .pullup_en(f_pullup_q[j]),
            .pad_in(pf_pad_in[j]),
            .pad_out(pf_pad_out[j]),
            .pad_oe(pf_pad_oe[j]),
            .pad_pullup(pf_pad_pullup[j]),
            .pin_sync(f_pin_sync[j])
        );
    end

endmodule

`default_nettype wire

// ==== pbfm_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pbfm_defines.svh"
module pbfm_checker (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic emi_bus_active,
    input wire logic [4:0] pb_pad_oe,
    input wire logic [4:0] pb_pad_pullup,
    input wire logic [3:0] pf_pad_oe,
    input wire logic [3:0] pf_pad_pullup,
    input wire logic emi_ctrl_oe,
    input wire pbfm_pkg::pbfm_fn_e shared_pin_fn
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    reset_fn_a: assert property ($rose(rstn) |-> shared_pin_fn == pbfm_pkg::PBFM_FN_GPIO)
        else $error("shared pin not gpio after reset");
    reset_oe_a: assert property ($rose(rstn) |-> pf_pad_oe == 4'h0 && pb_pad_oe == 5'h00)
        else $error("pads driven after reset");
    pull_b_a: assert property ((reg_wr && reg_addr == `PBFM_OFF_B_PULLUP) ##1 !reg_wr
        |=> pb_pad_pullup == $past(reg_wdata[4:0], 2)) else $error("port b pull-up wrong");
    pull_f_a: assert property ((reg_wr && reg_addr == `PBFM_OFF_F_PULLUP) ##1 !reg_wr
        |=> pf_pad_pullup == $past(reg_wdata[3:0], 2)) else $error("port f pull-up wrong");
    fn_write_a: assert property ($changed(shared_pin_fn) |-> $past(reg_wr) || $past(reg_wr, 2))
        else $error("pin function changed without a write");
    clk_oe_a: assert property ((shared_pin_fn == pbfm_pkg::PBFM_FN_CLK) [*2] |-> pb_pad_oe[4])
        else $error("clock output not driven");
    addr_act_a: assert property ((emi_bus_active && shared_pin_fn == pbfm_pkg::PBFM_FN_ADDR) [*3]
        |-> pb_pad_oe[4] && emi_ctrl_oe) else $error("address pin idle during bus cycle");
    addr_idle_a: assert property ((!emi_bus_active && !reg_wr
        && shared_pin_fn == pbfm_pkg::PBFM_FN_ADDR) [*3] |-> pb_pad_oe[4] == emi_ctrl_oe)
        else $error("address pin and control enable disagree");
endmodule
bind pbfm_port_b_f_mux pbfm_checker u_chk (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr,
    .emi_bus_active, .pb_pad_oe, .pb_pad_pullup, .pf_pad_oe, .pf_pad_pullup, .emi_ctrl_oe,
    .shared_pin_fn);
`default_nettype wire

// ==== pbfm_emi_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pbfm_emi_model (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic go,
    input wire logic clk_run,
    input wire logic [4:0] addr,
    input wire logic [3:0] wdata,
    output logic [4:0] emi_addr_out,
    output logic [3:0] emi_data_out,
    output logic emi_data_oe,
    output logic emi_bus_active,
    output logic prescaler_clock
);
    logic [2:0] left_q;
    // Released lines toggle each cycle so a stale value never looks valid.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            left_q <= 3'h0;
            emi_addr_out <= 5'h00;
            emi_data_out <= 4'h0;
        end else if (go) begin
            left_q <= 3'h6;
            emi_addr_out <= addr;
            emi_data_out <= wdata;
        end else if (left_q != 3'h0) begin
            left_q <= left_q - 3'h1;
        end else begin
            emi_addr_out <= ~emi_addr_out;
            emi_data_out <= ~emi_data_out;
        end
    end
    assign emi_bus_active = left_q != 3'h0;
    assign emi_data_oe = left_q != 3'h0;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            prescaler_clock <= 1'b0;
        end else begin
            prescaler_clock <= clk_run ? ~prescaler_clock : 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHECK(a, e) begin compares++; if ((a) !== (e)) begin errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
    logic clk_sys = 1'b0;
    logic rstn, reg_wr, reg_rd, go, clk_run, prev;
    logic [3:0] reg_addr, pf_pad_in, mdata, emi_data_out, pf_pad_out, pf_pad_oe, pf_pad_pullup;
    logic [3:0] emi_data_in;
    logic [15:0] reg_wdata, reg_rdata;
    logic [4:0] maddr, emi_addr_out, pb_pad_in, pb_pad_out, pb_pad_oe, pb_pad_pullup;
    logic emi_data_oe, emi_bus_active, prescaler_clock, emi_ctrl_oe;
    pbfm_pkg::pbfm_fn_e shared_pin_fn;
    int errors = 0, compares = 0, cycles = 0, n;
    always #10 clk_sys = ~clk_sys;
    pbfm_port_b_f_mux dut (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .emi_addr_out, .emi_data_out, .emi_data_oe, .emi_bus_active, .prescaler_clock,
        .pb_pad_in, .pb_pad_out, .pb_pad_oe, .pb_pad_pullup, .pf_pad_in, .pf_pad_out,
        .pf_pad_oe, .pf_pad_pullup, .emi_data_in, .emi_ctrl_oe, .shared_pin_fn);
    pbfm_emi_model u_emi (.clk_sys, .rstn, .go, .clk_run, .addr(maddr), .wdata(mdata),
        .emi_addr_out, .emi_data_out, .emi_data_oe, .emi_bus_active, .prescaler_clock);
    // ********************************
    // Register access and helpers.
    // ********************************
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        `CHECK(reg_rdata, e)
    endtask
    task settle;
        repeat (4) @(posedge clk_sys);
        #1;
    endtask
    task done(input string s);
        $display("test %s done", s);
    endtask
    task print_verdict;
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        {rstn, reg_wr, reg_rd, go, clk_run} = 5'h00;
        {reg_addr, reg_wdata, pb_pad_in, pf_pad_in, maddr, mdata} = 38'h0;
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        #1;
        `CHECK(shared_pin_fn, pbfm_pkg::PBFM_FN_GPIO)
        `CHECK(pb_pad_pullup, 5'h1F)
        `CHECK(pf_pad_pullup, 4'hF)
        `CHECK(pf_pad_oe, 4'h0)
        rd(4'h6, 16'h000F);
        rd(4'hC, 16'h0000);
        `CHECK(shared_pin_fn, pbfm_pkg::PBFM_FN_GPIO)
        `CHECK(pb_pad_oe, 5'h00)
        done("reset");
        wr(4'h0, 16'h000F);
        wr(4'h5, 16'h000E);
        settle();
        `CHECK(pb_pad_pullup, 5'h0F)
        `CHECK(pf_pad_pullup, 4'hE)
        rd(4'h0, 16'h000F);
        done("pullup");
        wr(4'h1, 16'h001F);
        wr(4'h2, 16'h0005);
        wr(4'h3, 16'h001F);
        pb_pad_in <= 5'h15;
        settle();
        `CHECK(pb_pad_oe, 5'h05)
        `CHECK(pb_pad_out & pb_pad_oe, 5'h05)
        rd(4'h4, 16'h0015);
        wr(4'h2, 16'h000A);
        settle();
        `CHECK(pb_pad_oe, 5'h0A)
        done("gpio");
        wr(4'h1, 16'h000F);
        wr(4'hA, 16'h0000);
        wr(4'hB, 16'h0001);
        settle();
        `CHECK(shared_pin_fn, pbfm_pkg::PBFM_FN_ADDR)
        `CHECK(pb_pad_oe[4], 1'b1)
        wr(4'hB, 16'h0000);
        settle();
        `CHECK(pb_pad_oe[4], 1'b0)
        `CHECK(emi_ctrl_oe, 1'b0)
        `CHECK(pf_pad_oe, 4'h0)
        @(posedge clk_sys);
        {maddr, mdata, go} <= {5'h10, 4'h9, 1'b1};
        @(posedge clk_sys);
        go <= 1'b0;
        settle();
        `CHECK({pb_pad_oe[4], pb_pad_out[4]}, 2'h3)
        `CHECK({pf_pad_oe, pf_pad_out}, 8'hF9)
        done("address");
        wr(4'hA, 16'h0001);
        clk_run <= 1'b1;
        settle();
        `CHECK(shared_pin_fn, pbfm_pkg::PBFM_FN_CLK)
        n = 0;
        prev = pb_pad_out[4];
        repeat (16) begin
            @(posedge clk_sys);
            #1;
            if (pb_pad_out[4] !== prev) n++;
            prev = pb_pad_out[4];
        end
        `CHECK(n, 16)
        done("clock");
        wr(4'h6, 16'h0000);
        wr(4'h7, 16'h000F);
        wr(4'h8, 16'h000A);
        pf_pad_in <= 4'h5;
        settle();
        `CHECK(pf_pad_oe, 4'hF)
        `CHECK(pf_pad_out, 4'hA)
        `CHECK(emi_data_in, 4'h5)
        rd(4'h9, 16'h0005);
        done("port f");
        print_verdict();
    end
endmodule
`default_nettype wire
